// File: pcr_pkg.sv
// pcr_pkg: addresses, reset values, limits, timing and carriers of the probe
// configuration register bank. assumes one 10 MHz clock and 16-bit registers.
package pcr_pkg;

   // register addresses (16-bit register words)
   localparam logic [15:0] A_PRES_VOL_LO = 16'h0300;
   localparam logic [15:0] A_PRES_VOL_HI = 16'h0301;
   localparam logic [15:0] A_TSET_VOL_LO = 16'h0302;
   localparam logic [15:0] A_TSET_VOL_HI = 16'h0303;
   localparam logic [15:0] A_PRES_PUP_LO = 16'h0304;
   localparam logic [15:0] A_PRES_PUP_HI = 16'h0305;
   localparam logic [15:0] A_TSET_PUP_LO = 16'h0306;
   localparam logic [15:0] A_TSET_PUP_HI = 16'h0307;
   localparam logic [15:0] A_PURGE       = 16'h0502;
   localparam logic [15:0] A_PCOMP       = 16'h0504;
   localparam logic [15:0] A_TCOMP       = 16'h0505;
   localparam logic [15:0] A_MPURGE      = 16'h0506;
   localparam logic [15:0] A_IPURGE      = 16'h0507;
   localparam logic [15:0] A_STATION     = 16'h0600;
   localparam logic [15:0] A_BAUD        = 16'h0601;
   localparam logic [15:0] A_FRAME       = 16'h0602;
   localparam logic [15:0] A_DELAY       = 16'h0603;
   localparam logic [15:0] A_RESTART     = 16'h0604;
   localparam logic [15:0] A_AOUT1       = 16'h0700;

   // reset values
   localparam logic        RST_PCOMP    = 1'h0;
   localparam logic        RST_TCOMP    = 1'h1;
   localparam logic        RST_MPURGE   = 1'h1;
   localparam logic        RST_IPURGE   = 1'h0;
   localparam logic [7:0]  RST_STATION  = 8'hf0;
   localparam logic [3:0]  RST_BAUD     = 4'h6;
   localparam logic [2:0]  RST_FRAME    = 3'h1;
   localparam logic [9:0]  RST_DELAY    = 10'h000;
   localparam logic [1:0]  RST_AOUT1    = 2'h2;
   localparam logic [31:0] RST_PRES_PUP = 32'h447d5000; // 1013.25 hPa
   localparam logic [31:0] RST_TSET_PUP = 32'h00000000;

   // value limits and codes
   localparam logic [15:0] STATION_MIN  = 16'h0001;
   localparam logic [15:0] STATION_MAX  = 16'h00ff;
   localparam logic [15:0] BAUD_MIN     = 16'h0005;
   localparam logic [15:0] BAUD_MAX     = 16'h0009;
   localparam logic [15:0] FRAME_MAX    = 16'h0005;
   localparam logic [15:0] DELAY_MAX    = 16'h03e8;
   localparam logic [15:0] BOOL_MAX     = 16'h0001;
   localparam logic [15:0] AOUT_OFF     = 16'h0000;
   localparam logic [15:0] AOUT_CURRENT = 16'h0002;
   localparam logic [15:0] CMD_GO       = 16'h0001;
   localparam logic [15:0] PURGE_FAILED = 16'hffff;
   localparam logic [6:0]  PROG_MIN     = 7'h01;
   localparam logic [6:0]  PROG_MAX     = 7'h64;
   localparam logic [3:0]  DATA_BITS    = 4'h8;

   // answer codes
   localparam logic [7:0] EXC_NONE  = 8'h00;
   localparam logic [7:0] EXC_FUNC  = 8'h01;
   localparam logic [7:0] EXC_ADDR  = 8'h02;
   localparam logic [7:0] EXC_VALUE = 8'h03;
   localparam logic [7:0] EXC_BUSY  = 8'h06;

   // timing
   localparam int CLK_PERIOD_NS = 100;
   localparam int MS_NS         = 1000000;
   localparam int CYCLES_PER_MS = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   typedef enum logic [1:0] {PAR_NONE = 2'h0, PAR_EVEN = 2'h1, PAR_ODD = 2'h2} pcr_parity_e;

   typedef struct packed {
      logic        write;
      logic [15:0] addr;
      logic [15:0] wdata;
   } pcr_req_s;

   typedef struct packed {
      logic [15:0] rdata;
      logic [7:0]  exc;
   } pcr_rsp_s;

   typedef struct packed {
      logic [7:0]  station;
      logic [16:0] baud_rate;
      pcr_parity_e parity;
      logic        two_stop;
      logic [3:0]  data_bits;
      logic [9:0]  reply_delay;
   } pcr_link_s;

   typedef struct packed {
      logic        pres_en;
      logic [31:0] pres_value;
      logic        temp_setpoint_mode;
      logic [31:0] temp_setpoint;
   } pcr_comp_s;

endpackage

// File: pcr_reply_timer.sv
// pcr_reply_timer: counts a reply delay given in milliseconds.
// assumes start is a one-cycle pulse and is not repeated while counting.
`timescale 1ns/10ps
module pcr_reply_timer #(
   parameter int CYCLES_PER_MS = pcr_pkg::CYCLES_PER_MS
) (
   input  wire logic       mclk,     // system clock
   input  wire logic       resetn,   // synchronous reset, active low
   input  wire logic       start,    // begin a delay
   input  wire logic [9:0] delay_ms, // delay length in ms
   output logic            done      // one-cycle pulse at delay end
);

   initial begin
      if (CYCLES_PER_MS < 1 || CYCLES_PER_MS > 1048576) begin
         $error("pcr_reply_timer: CYCLES_PER_MS out of range");
      end
   end

   logic        busy;
   logic [19:0] pre;
   logic [9:0]  ms_left;
   wire         ms_tick = (pre == 20'(CYCLES_PER_MS - 1));

   // prescaler to milliseconds, then a millisecond down-count
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         busy    <= 1'h0;
         pre     <= 20'h00000;
         ms_left <= 10'h000;
         done    <= 1'h0;
      end else begin
         done <= 1'h0;
         if (start) begin
            busy    <= 1'h1;
            pre     <= 20'h00000;
            ms_left <= delay_ms;
         end else if (busy && ms_left == 10'h000) begin
            busy <= 1'h0;
            done <= 1'h1;
         end else if (busy && ms_tick) begin
            pre     <= 20'h00000;
            ms_left <= ms_left - 10'h001;
         end else if (busy) begin
            pre <= pre + 20'h00001;
         end
      end
   end

endmodule

// File: pcr_bank.sv
// pcr_bank: configuration and command registers of the probe, served to a
// request/answer port fed by the serial frame decoder on the same clock.
// assumes the purge engine runs on mclk and restart_req resets the system.
`timescale 1ns/10ps

// How it works
// - busy purge reads progress 1..100, idle 0
// - failed purge reads back distinct code ffff
// - write 1 starts purge; writes refused while running
// - compensation select 0 probe, 1 setpoint; reset 1
// - setpoint taken from volatile copy, loaded from power-up
// - manual purge in analog mode enable, default on
// - station address 1..255, reset 240
// - bit rate codes 5..9, reset code 6
// - framing codes 0..5, eight data bits, reset 1
// - writing 1 requests full device restart
// - analog output 1 mode 0 off, 2 current
// - pressure value volatile, cleared, loaded from power-up
module pcr_bank #(
   parameter int CYCLES_PER_MS = pcr_pkg::CYCLES_PER_MS
) (
   input  wire logic                mclk,           // system clock, 10 MHz
   input  wire logic                resetn,         // synchronous reset, active low
   input  wire logic                req_valid,      // request offered
   input  wire pcr_pkg::pcr_req_s   req,            // request content
   output logic                     req_ready,      // bank can take a request
   output logic                     rsp_valid,      // answer pulse
   output pcr_pkg::pcr_rsp_s        rsp,            // answer content
   input  wire logic                purge_busy,     // purge engine running
   input  wire logic [6:0]          purge_progress, // purge progress percent
   input  wire logic                purge_fail,     // purge failed pulse
   output logic                     purge_start,    // start purge pulse
   output logic                     restart_req,    // full restart pulse
   output pcr_pkg::pcr_comp_s       comp,           // compensation settings
   output pcr_pkg::pcr_link_s       link_cfg,       // serial link settings
   output logic                     manual_purge_en,// manual purge in analog mode
   output logic                     ipurge_allow,   // interval purge in exposure
   output logic                     aout1_on        // analog output 1 current mode
);

   initial begin
      if (CYCLES_PER_MS < 1) begin
         $error("pcr_bank: CYCLES_PER_MS must be at least 1");
      end
   end

   typedef enum logic [1:0] {ST_IDLE = 2'h1, ST_WAIT = 2'h2} pcr_state_e;

   // range check shared by the bool, station, bit rate, framing and delay writes
   function automatic logic in_range(input logic [15:0] v,
                                     input logic [15:0] lo,
                                     input logic [15:0] hi);
      in_range = (v >= lo) && (v <= hi);
   endfunction

   // bit rate code to baud
   function automatic logic [16:0] baud_of(input logic [3:0] code);
      case (code)
         4'h5:    baud_of = 17'd9600;
         4'h6:    baud_of = 17'd19200;
         4'h7:    baud_of = 17'd38400;
         4'h8:    baud_of = 17'd57600;
         default: baud_of = 17'd115200;
      endcase
   endfunction

   pcr_state_e  state;
   pcr_state_e  next_state;
   logic [3:0]  baud_code;
   logic [2:0]  frame_code;
   logic [1:0]  aout1_mode;
   logic [31:0] pres_pup;
   logic [31:0] tset_pup;
   logic        init_load;
   logic        purge_pending;
   logic        purge_failed;
   logic        restart_pend;
   logic        timer_done;

   // request decode
   wire        take   = req_valid && req_ready;
   wire        wr     = take && req.write;
   wire [15:0] a      = req.addr;
   wire [15:0] d      = req.wdata;
   wire        is_bool = in_range(d, 16'h0000, pcr_pkg::BOOL_MAX);

   wire hit_pres_lo  = (a == pcr_pkg::A_PRES_VOL_LO);
   wire hit_pres_hi  = (a == pcr_pkg::A_PRES_VOL_HI);
   wire hit_tset_lo  = (a == pcr_pkg::A_TSET_VOL_LO);
   wire hit_tset_hi  = (a == pcr_pkg::A_TSET_VOL_HI);
   wire hit_ppup_lo  = (a == pcr_pkg::A_PRES_PUP_LO);
   wire hit_ppup_hi  = (a == pcr_pkg::A_PRES_PUP_HI);
   wire hit_tpup_lo  = (a == pcr_pkg::A_TSET_PUP_LO);
   wire hit_tpup_hi  = (a == pcr_pkg::A_TSET_PUP_HI);
   wire hit_purge    = (a == pcr_pkg::A_PURGE);
   wire hit_pcomp    = (a == pcr_pkg::A_PCOMP);
   wire hit_tcomp    = (a == pcr_pkg::A_TCOMP);
   wire hit_mpurge   = (a == pcr_pkg::A_MPURGE);
   wire hit_ipurge   = (a == pcr_pkg::A_IPURGE);
   wire hit_station  = (a == pcr_pkg::A_STATION);
   wire hit_baud     = (a == pcr_pkg::A_BAUD);
   wire hit_frame    = (a == pcr_pkg::A_FRAME);
   wire hit_delay    = (a == pcr_pkg::A_DELAY);
   wire hit_restart  = (a == pcr_pkg::A_RESTART);
   wire hit_aout1    = (a == pcr_pkg::A_AOUT1);

   wire hit_float = hit_pres_lo | hit_pres_hi | hit_tset_lo | hit_tset_hi |
                    hit_ppup_lo | hit_ppup_hi | hit_tpup_lo | hit_tpup_hi;
   wire hit_any   = hit_float | hit_purge | hit_pcomp | hit_tcomp |
                    hit_mpurge | hit_ipurge | hit_station | hit_baud |
                    hit_frame | hit_delay | hit_restart | hit_aout1;

   // purge start is refused while one runs or when analog mode forbids it
   wire purge_running = purge_busy | purge_pending;
   wire purge_blocked = aout1_on && !manual_purge_en;

   // value check per register
   wire val_ok =
      hit_float                                                 ? 1'h1 :
      (hit_purge | hit_restart)                                 ? (d == pcr_pkg::CMD_GO) :
      (hit_pcomp | hit_tcomp | hit_mpurge | hit_ipurge)         ? is_bool :
      hit_station ? in_range(d, pcr_pkg::STATION_MIN, pcr_pkg::STATION_MAX) :
      hit_baud    ? in_range(d, pcr_pkg::BAUD_MIN, pcr_pkg::BAUD_MAX) :
      hit_frame   ? in_range(d, 16'h0000, pcr_pkg::FRAME_MAX) :
      hit_delay   ? in_range(d, 16'h0000, pcr_pkg::DELAY_MAX) :
      hit_aout1   ? (d == pcr_pkg::AOUT_OFF || d == pcr_pkg::AOUT_CURRENT) :
      1'h0;

   // answer code for a write
   wire [7:0] wr_exc =
      !hit_any                        ? pcr_pkg::EXC_ADDR :
      !val_ok                         ? pcr_pkg::EXC_VALUE :
      (hit_purge && purge_running)    ? pcr_pkg::EXC_BUSY :
      (hit_purge && purge_blocked)    ? pcr_pkg::EXC_FUNC :
      pcr_pkg::EXC_NONE;

   wire do_wr = wr && (wr_exc == pcr_pkg::EXC_NONE);

   // purge status word: running shows progress, failure a code of its own
   wire [6:0] prog_clamped =
      (purge_progress < pcr_pkg::PROG_MIN) ? pcr_pkg::PROG_MIN :
      (purge_progress > pcr_pkg::PROG_MAX) ? pcr_pkg::PROG_MAX :
      purge_progress;
   wire [15:0] purge_word =
      purge_busy    ? {9'h000, prog_clamped} :
      purge_pending ? {9'h000, pcr_pkg::PROG_MIN} :
      purge_failed  ? pcr_pkg::PURGE_FAILED :
      16'h0000;

   // read selection; low word of a float sits at the lower address
   wire [15:0] rd_data =
      hit_pres_lo ? comp.pres_value[15:0] :
      hit_pres_hi ? comp.pres_value[31:16] :
      hit_tset_lo ? comp.temp_setpoint[15:0] :
      hit_tset_hi ? comp.temp_setpoint[31:16] :
      hit_ppup_lo ? pres_pup[15:0] :
      hit_ppup_hi ? pres_pup[31:16] :
      hit_tpup_lo ? tset_pup[15:0] :
      hit_tpup_hi ? tset_pup[31:16] :
      hit_purge   ? purge_word :
      hit_pcomp   ? {15'h0000, comp.pres_en} :
      hit_tcomp   ? {15'h0000, comp.temp_setpoint_mode} :
      hit_mpurge  ? {15'h0000, manual_purge_en} :
      hit_ipurge  ? {15'h0000, ipurge_allow} :
      hit_station ? {8'h00, link_cfg.station} :
      hit_baud    ? {12'h000, baud_code} :
      hit_frame   ? {13'h0000, frame_code} :
      hit_delay   ? {6'h00, link_cfg.reply_delay} :
      hit_aout1   ? {14'h0000, aout1_mode} :
      16'h0000;   // restart reads as zero

   wire [7:0] rd_exc = hit_any ? pcr_pkg::EXC_NONE : pcr_pkg::EXC_ADDR;

   // answer sequencing: one request at a time, answer after the delay
   always_comb begin
      next_state = state;
      unique case (state)
         ST_IDLE: begin
            if (take) begin
               next_state = ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (timer_done) begin
               next_state = ST_IDLE;
            end
         end
      endcase
   end

   pcr_reply_timer #(
      .CYCLES_PER_MS (CYCLES_PER_MS)
   ) u_timer (
      .mclk     (mclk),
      .resetn   (resetn),
      .start    (take),
      .delay_ms (link_cfg.reply_delay),
      .done     (timer_done)
   );

   // state, ready and answer
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         state     <= ST_IDLE;
         req_ready <= 1'h0;
         rsp_valid <= 1'h0;
         rsp       <= '0;
      end else begin
         state     <= next_state;
         req_ready <= (next_state == ST_IDLE);
         rsp_valid <= (state == ST_WAIT) && timer_done;
         if (take) begin
            rsp.rdata <= req.write ? d : rd_data;
            rsp.exc   <= req.write ? wr_exc : rd_exc;
         end
      end
   end

   // command pulses; restart pulses in the same cycle as its own answer
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         purge_start  <= 1'h0;
         restart_req  <= 1'h0;
         restart_pend <= 1'h0;
      end else begin
         purge_start <= do_wr && hit_purge;
         restart_req <= restart_pend && timer_done;
         if (do_wr && hit_restart) begin
            restart_pend <= 1'h1;
         end else if (timer_done) begin
            restart_pend <= 1'h0;
         end
      end
   end

   // purge bookkeeping; a failure in the start cycle still sticks
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         purge_pending <= 1'h0;
         purge_failed  <= 1'h0;
      end else begin
         if (do_wr && hit_purge) begin
            purge_pending <= 1'h1;
         end else if (purge_busy) begin
            purge_pending <= 1'h0;
         end
         if (purge_fail) begin
            purge_failed <= 1'h1;
         end else if (do_wr && hit_purge) begin
            purge_failed <= 1'h0;
         end
      end
   end

   // volatile values: cleared at reset, loaded from power-up copies next
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         init_load          <= 1'h1;
         comp.pres_value    <= 32'h00000000;
         comp.temp_setpoint <= 32'h00000000;
      end else begin
         init_load <= 1'h0;
         if (init_load) begin
            comp.pres_value    <= pres_pup;
            comp.temp_setpoint <= tset_pup;
         end else begin
            if (do_wr && hit_pres_lo) comp.pres_value[15:0]     <= d;
            if (do_wr && hit_pres_hi) comp.pres_value[31:16]    <= d;
            if (do_wr && hit_tset_lo) comp.temp_setpoint[15:0]  <= d;
            if (do_wr && hit_tset_hi) comp.temp_setpoint[31:16] <= d;
         end
      end
   end

   // power-up copies; reset restores their constants, so written values never reach the volatile copies
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         pres_pup <= pcr_pkg::RST_PRES_PUP;
         tset_pup <= pcr_pkg::RST_TSET_PUP;
      end else begin
         if (do_wr && hit_ppup_lo) pres_pup[15:0]  <= d;
         if (do_wr && hit_ppup_hi) pres_pup[31:16] <= d;
         if (do_wr && hit_tpup_lo) tset_pup[15:0]  <= d;
         if (do_wr && hit_tpup_hi) tset_pup[31:16] <= d;
      end
   end

   // compensation and purge enables
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         comp.pres_en            <= pcr_pkg::RST_PCOMP;
         comp.temp_setpoint_mode <= pcr_pkg::RST_TCOMP;
         manual_purge_en         <= pcr_pkg::RST_MPURGE;
         ipurge_allow            <= pcr_pkg::RST_IPURGE;
      end else begin
         if (do_wr && hit_pcomp)  comp.pres_en            <= d[0];
         if (do_wr && hit_tcomp)  comp.temp_setpoint_mode <= d[0];
         if (do_wr && hit_mpurge) manual_purge_en         <= d[0];
         if (do_wr && hit_ipurge) ipurge_allow            <= d[0];
      end
   end

   // serial link settings; new values apply to the link from the next frame
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         link_cfg.station     <= pcr_pkg::RST_STATION;
         baud_code            <= pcr_pkg::RST_BAUD;
         link_cfg.baud_rate   <= baud_of(pcr_pkg::RST_BAUD);
         frame_code           <= pcr_pkg::RST_FRAME;
         link_cfg.parity      <= pcr_pkg::PAR_NONE;
         link_cfg.two_stop    <= 1'h1;
         link_cfg.data_bits   <= pcr_pkg::DATA_BITS;
         link_cfg.reply_delay <= pcr_pkg::RST_DELAY;
      end else begin
         if (do_wr && hit_station) link_cfg.station <= d[7:0];
         if (do_wr && hit_baud) begin
            baud_code          <= d[3:0];
            link_cfg.baud_rate <= baud_of(d[3:0]);
         end
         if (do_wr && hit_frame) begin
            frame_code        <= d[2:0];
            link_cfg.two_stop <= d[0];
            link_cfg.parity   <= (d[2:1] == 2'h0) ? pcr_pkg::PAR_NONE :
                                 (d[2:1] == 2'h1) ? pcr_pkg::PAR_EVEN :
                                 pcr_pkg::PAR_ODD;
         end
         if (do_wr && hit_delay) link_cfg.reply_delay <= d[9:0];
      end
   end

   // analog output 1 mode
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         aout1_mode <= pcr_pkg::RST_AOUT1;
         aout1_on   <= 1'h1;
      end else if (do_wr && hit_aout1) begin
         aout1_mode <= d[1:0];
         aout1_on   <= (d == pcr_pkg::AOUT_CURRENT);
      end
   end

endmodule

// File: pcr_bank_assertions.sv
// pcr_bank_assertions: port checker of the probe register bank.
// assumes it is bound to pcr_bank and sees only its ports.
`timescale 1ns/10ps
module pcr_bank_chk #(
   parameter int CYCLES_PER_MS = 4
) (
   input wire logic               mclk,        // clock
   input wire logic               resetn,      // reset, active low
   input wire logic               req_valid,   // request offered
   input wire pcr_pkg::pcr_req_s  req,         // request
   input wire logic               req_ready,   // bank idle
   input wire logic               rsp_valid,   // answer pulse
   input wire pcr_pkg::pcr_rsp_s  rsp,         // answer
   input wire logic               purge_start, // start pulse
   input wire logic               restart_req, // restart pulse
   input wire pcr_pkg::pcr_link_s link_cfg     // link settings
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!resetn);
   // a take is the only moment the bank accepts work
   wire take = req_valid && req_ready;
   wire delay_wr = req.write && req.addr == 16'h0603;

   // one request at a time, and a zero delay answers on the third edge
   chk_ready_drop: assert property (take |=> !req_ready)
      else $error("ready stayed high after a take");
   chk_answer_time: assert property (take && link_cfg.reply_delay == 10'h000 && !delay_wr
      |=> !rsp_valid [*2] ##1 rsp_valid) else $error("answer not on time");
   // restart goes out with a clean answer, purge start only after a write to the purge address
   chk_restart_pair: assert property (restart_req |-> rsp_valid && rsp.exc == 8'h00)
      else $error("restart without its answer");
   chk_start_cause: assert property (purge_start |-> $past(take && req.write && req.addr == 16'h0502))
      else $error("purge start without a write");
   chk_start_pulse: assert property (purge_start |=> !purge_start)
      else $error("purge start longer than one cycle");
   // refused values must never reach the link settings
   chk_station_nonzero: assert property (link_cfg.station != 8'h00)
      else $error("station address zero");
   chk_baud_legal: assert property (link_cfg.baud_rate inside {17'h02580, 17'h04b00, 17'h09600, 17'h0e100,
      17'h1c200}) else $error("illegal bit rate");
   chk_frame_legal: assert property (link_cfg.data_bits == 4'h8 && link_cfg.parity != 2'h3)
      else $error("illegal framing");
   cov_restart: cover property (restart_req);
   cov_purge: cover property (purge_start);
   cov_busy: cover property (rsp_valid && rsp.exc == 8'h06);
endmodule
bind pcr_bank pcr_bank_chk #(.CYCLES_PER_MS(CYCLES_PER_MS)) chk_u (.mclk, .resetn, .req_valid, .req,
   .req_ready, .rsp_valid, .rsp, .purge_start, .restart_req, .link_cfg);

// File: pcr_host.sv
// pcr_host: serial master model feeding the bank's request port.
// assumes one outstanding request and the bank's clock.
`timescale 1ns/10ps
module pcr_host (
   input  wire logic               mclk,      // clock
   output logic                    req_valid, // request offered
   output pcr_pkg::pcr_req_s       req,       // request
   input  wire logic               req_ready, // bank idle
   input  wire logic               rsp_valid, // answer pulse
   input  wire pcr_pkg::pcr_rsp_s  rsp        // answer
);
   // idle until the first request
   initial begin
      req_valid = 1'b0;
      req = '0;
   end
   // held until taken, then scrambled so stale fields are never mistaken for live ones
   task automatic xfer(input logic wr, input logic [15:0] a, input logic [15:0] d,
                       output pcr_pkg::pcr_rsp_s r, output int lat);
      int n;
      @(posedge mclk);
      req_valid <= 1'b1;
      req <= '{write: wr, addr: a, wdata: d};
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (!req_ready && n < 100);
      req_valid <= 1'b0;
      req <= ~req;
      lat = 0;
      do begin
         @(posedge mclk);
         lat++;
      end while (!rsp_valid && lat < 20000);
      r = rsp;
   endtask
endmodule

// File: tb_top.sv
// tb_top: self-checking bench of the probe register bank.
// assumes pcr_host as request master and the bench as purge engine.
`timescale 1ns/10ps
module tb_top;
   localparam int CPM = 4;
   logic mclk, resetn, req_valid, req_ready, rsp_valid, purge_busy, purge_fail;
   logic purge_start, restart_req, manual_purge_en, ipurge_allow, aout1_on;
   logic [6:0] purge_progress;
   pcr_pkg::pcr_req_s req;
   pcr_pkg::pcr_rsp_s rsp, r;
   pcr_pkg::pcr_comp_s comp;
   pcr_pkg::pcr_link_s link_cfg;
   int lat, bad_count, checks;

   pcr_bank #(.CYCLES_PER_MS(CPM)) dut_u (.mclk, .resetn, .req_valid, .req, .req_ready, .rsp_valid, .rsp,
      .purge_busy, .purge_progress, .purge_fail, .purge_start, .restart_req, .comp, .link_cfg,
      .manual_purge_en, .ipurge_allow, .aout1_on);
   pcr_host host_u (.mclk, .req_valid, .req, .req_ready, .rsp_valid, .rsp);

   // 10 MHz clock
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic results();
      if (bad_count == 0 && checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   // one access; a lost answer ends the run
   task automatic acc(input logic wr, input logic [15:0] a, input logic [15:0] d);
      host_u.xfer(wr, a, d, r, lat);
      if (lat >= 20000) begin
         bad_count++;
         $display("mismatch at %0t: no answer", $time);
         results();
      end
   endtask

   task automatic do_reset();
      resetn <= 1'b0;
      repeat (4) @(posedge mclk);
      resetn <= 1'b1;
      @(posedge mclk);
   endtask

   // reset values read back, plus an unmapped address
   task automatic t_reset();
      logic [15:0] ra [10] = '{16'h0505, 16'h0506, 16'h0507, 16'h0600, 16'h0601, 16'h0602, 16'h0603,
                               16'h0700, 16'h0604, 16'h0504};
      logic [15:0] rv [10] = '{16'h1, 16'h1, 16'h0, 16'hf0, 16'h6, 16'h1, 16'h0, 16'h2, 16'h0, 16'h0};
      for (int i = 0; i < 10; i++) begin
         acc(1'b0, ra[i], 16'h0000);
         chk(r.rdata, rv[i]);
      end
      acc(1'b0, 16'h0508, 16'h0000);
      chk(r.exc, 8'h02);
      chk(comp.pres_value, 32'h447d5000);
      chk(link_cfg.baud_rate, 17'h04b00);
   endtask

   // link settings: bounds, every bit rate and framing code
   task automatic t_link();
      logic [16:0] br [5] = '{17'h02580, 17'h04b00, 17'h09600, 17'h0e100, 17'h1c200};
      int f;
      acc(1'b1, 16'h0600, 16'h0000);
      chk(link_cfg.station, 8'hf0);
      acc(1'b1, 16'h0600, 16'h00ff);
      chk(link_cfg.station, 8'hff);
      acc(1'b1, 16'h0601, 16'h000a);
      chk(r.exc, 8'h03);
      for (int i = 0; i < 5; i++) begin
         acc(1'b1, 16'h0601, 16'(i + 5));
         chk(link_cfg.baud_rate, br[i]);
      end
      for (int i = 0; i < 7; i++) begin
         acc(1'b1, 16'h0602, 16'(i));
         f = (i > 5) ? 5 : i; // a refused code leaves code 5 in place
         chk({r.exc, link_cfg.parity, link_cfg.two_stop}, {i == 6 ? 8'h03 : 8'h00, 2'(f / 2), f % 2 == 1});
      end
   endtask

   // compensation sources and analog mode codes
   task automatic t_comp();
      acc(1'b1, 16'h0504, 16'h0001);
      chk(comp.pres_en, 1'b1);
      acc(1'b1, 16'h0505, 16'h0000);
      chk(comp.temp_setpoint_mode, 1'b0);
      acc(1'b1, 16'h0303, 16'h41c8);
      chk(comp.temp_setpoint, 32'h41c80000);
      acc(1'b1, 16'h0301, 16'h4480);
      chk(comp.pres_value, 32'h44805000);
      acc(1'b1, 16'h0700, 16'h0001);
      chk(r.exc, 8'h03);
      acc(1'b1, 16'h0700, 16'h0000);
      chk(aout1_on, 1'b0);
      acc(1'b1, 16'h0507, 16'h0001);
      chk(ipurge_allow, 1'b1);
   endtask

   // purge gating, progress, refusal while running, failure and success
   task automatic t_purge();
      acc(1'b1, 16'h0700, 16'h0002);
      acc(1'b1, 16'h0506, 16'h0000);
      chk(manual_purge_en, 1'b0);
      acc(1'b1, 16'h0502, 16'h0001);
      chk(r.exc, 8'h01);
      acc(1'b1, 16'h0506, 16'h0001);
      acc(1'b1, 16'h0502, 16'h0001);
      chk(r.exc, 8'h00);
      purge_busy <= 1'b1;
      purge_progress <= 7'h32;
      acc(1'b0, 16'h0502, 16'h0000);
      chk(r.rdata, 16'h0032);
      acc(1'b1, 16'h0502, 16'h0001);
      chk(r.exc, 8'h06);
      purge_busy <= 1'b0;
      purge_fail <= 1'b1;
      @(posedge mclk);
      purge_fail <= 1'b0;
      acc(1'b0, 16'h0502, 16'h0000);
      chk(r.rdata, 16'hffff);
      acc(1'b1, 16'h0502, 16'h0001);
      purge_busy <= 1'b1;
      purge_progress <= 7'h64;
      acc(1'b0, 16'h0502, 16'h0000);
      chk(r.rdata, 16'h0064);
      purge_busy <= 1'b0;
      acc(1'b0, 16'h0502, 16'h0000);
      chk(r.rdata, 16'h0000);
   endtask

   // longest reply delay, an over-range delay, and restart
   task automatic t_misc();
      acc(1'b1, 16'h0603, 16'h03e9);
      chk(r.exc, 8'h03);
      acc(1'b1, 16'h0603, 16'h03e8);
      acc(1'b0, 16'h0600, 16'h0000);
      chk(lat, 3 + 1000 * CPM);
      acc(1'b1, 16'h0603, 16'h0000);
      acc(1'b1, 16'h0604, 16'h0002);
      chk(r.exc, 8'h03);
      acc(1'b1, 16'h0604, 16'h0001);
      chk(r.exc, 8'h00);
      chk(restart_req, 1'b1);
   endtask

   // main sequence, with a second reset in mid-run
   initial begin
      resetn = 1'b0;
      purge_busy = 1'b0;
      purge_fail = 1'b0;
      purge_progress = 7'h00;
      bad_count = 0;
      checks = 0;
      do_reset();
      t_reset();
      t_link();
      t_comp();
      t_purge();
      t_misc();
      do_reset();
      t_reset();
      results();
   end
endmodule
